// file: src/ecs_regs.vh
`ifndef ECS_REGS_VH
`define ECS_REGS_VH

// data and frame geometry
`define ECS_DATA_W 10
`define ECS_FRAME_BITS 12
`define ECS_FRAME_LAST 4'hB
`define ECS_HALF_FRAME 4'h6
`define ECS_START_BIT 1'b1
`define ECS_STOP_BIT 1'b0
// six ones then six zeros, first bit sent in bit 0
`define ECS_SYNC_FRAME 12'h03F

// timing counts, in transmit clock periods
`define ECS_TX_LOCK_CYCLES 10'h1FE
`define ECS_SYNC_IGNORE_CYCLES 3'h5

// register byte offsets
`define ECS_CTRL_OFS 8'h00
`define ECS_STAT_OFS 8'h04
`define ECS_CAND_OFS 8'h08
`define ECS_LOSS_OFS 8'h0C

// control fields
`define ECS_CTRL_RX_OE 0
`define ECS_CTRL_RX_EDGE 1
`define ECS_CTRL_RX_OE_RST 1'b1
`define ECS_CTRL_RX_EDGE_RST 1'b1

// status fields
`define ECS_STAT_RX_LOCK 0
`define ECS_STAT_TX_LOCK 1
`define ECS_STAT_AMBIG 2
`define ECS_STAT_TX_SYNC 3
`define ECS_STAT_TX_IGNORE 4
`define ECS_STAT_RX_SLEEP 5
`define ECS_STAT_TX_SLEEP 6
`define ECS_STAT_RX_PLL 7

`endif

// file: src/ecs_serdes.v
// Behaviour
// (R1) serial output undriven for 510 transmit clocks after reset or wake
// (R2) outside supplies reference clock; receive PLL locks to it before hunting
// (R3) either sync request high sends six ones then six zeros each frame
// (R4) data frames resume only once both sync requests are low
// (R5) lock indicator high while the receiver is still acquiring
// (R6) lock indicator low on lock; parallel outputs then carry received data
// (R7) words sampled on rising transmit clock edge if edge select high, else falling
// (R8) sync request high five transmit clocks makes parallel inputs ignored
// (R9) each word framed by start bit one and stop bit zero
// (R10) twelve bits shifted out per frame
// (R11) serial output driven only with enable, wake and acquisition done
// (R12) parallel outputs valid only while lock indicator is low
// (R13) parallel outputs timed by recovered clock with selectable active edge
// (R14) loss of lock raises indicator and releases data and clock outputs
// (R15) outside system pulses a sync request on loss of lock
// (R16) receiver locks to random data without any sync pattern
// (R17) several possible frame positions keep lock off and hunting on
// (R18) false lock comes from a low data bit next to a high one
// (R19) receiver sleeps with wake and enable low; transmitter with wake low
// (R20) sleep stops both PLLs and releases outputs until wake goes high
// (R21) after sleep both sides reacquire; lock indicator high until relock
// (R22) transmit enable low keeps all state so enabling resumes it
// (R23) receive enable low releases data and clock, lock indicator stays driven
// (R24) transmit PLL locks within 510 to 513 transmit clocks
// (R25) transmitter release makes the receiver lose lock and resynchronise
// (R26) start bit first, data bits zero to nine, then stop bit
// (R27) sync requests synchronised and counted in transmit clock periods
`timescale 1ns/1ps
`default_nettype none
`include "ecs_regs.vh"

module ecs_serdes #(
   parameter [3:0] LOCK_FRAMES = 4'h4,
   parameter [4:0] REF_EDGES = 5'h10
) (
   // system
   input wire clk,
   input wire rstn,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg wb_ack_o,
   output reg [31:0] wb_dat_o,
   // serializer pins
   input wire tx_parallel_clock,
   input wire sync_request_a,
   input wire sync_request_b,
   input wire tx_edge_select,
   input wire tx_output_enable,
   input wire sleep_control_n,
   input wire [9:0] tx_parallel_in,
   output reg tx_serial_out,
   output reg tx_serial_oe,
   // deserializer pins
   input wire rx_serial_in,
   input wire rx_reference_clock,
   output reg [9:0] rx_parallel_out,
   output reg rx_parallel_oe,
   output reg rx_recovered_clock,
   output reg rx_clock_oe,
   output reg rx_lock_n
);

   localparam [3:0] ST_SLEEP = 4'h1;
   localparam [3:0] ST_ACQ = 4'h2;
   localparam [3:0] ST_HUNT = 4'h4;
   localparam [3:0] ST_LOCK = 4'h8;

   function [3:0] ones_count;
      input [11:0] v;
      integer i;
      begin
         ones_count = 4'h0;
         for (i = 0; i < 12; i = i + 1) begin
            ones_count = ones_count + {3'h0, v[i]};
         end
      end
   endfunction

   function [3:0] first_index;
      input [11:0] v;
      integer i;
      begin
         first_index = 4'h0;
         for (i = 11; i >= 0; i = i - 1) begin
            if (v[i]) begin
               first_index = i[3:0];
            end
         end
      end
   endfunction

   // every serializer and deserializer pin passes two flops before any logic reads it
   wire [17:0] pin_raw;
   reg [17:0] pin_s1;
   reg [17:0] pin_s2;
   assign pin_raw = {rx_reference_clock, rx_serial_in, tx_parallel_in,
                     sleep_control_n, tx_output_enable, tx_edge_select,
                     sync_request_b, sync_request_a, tx_parallel_clock};

   always @(posedge clk) begin
      if (!rstn) begin
         pin_s1 <= 18'h00000;
         pin_s2 <= 18'h00000;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   wire tx_parallel_clock_s = pin_s2[0];
   wire sync_a_s = pin_s2[1];
   wire sync_b_s = pin_s2[2];
   wire edge_s = pin_s2[3];
   wire tx_oe_s = pin_s2[4];
   wire wake_s = pin_s2[5];
   wire [9:0] din_s = pin_s2[15:6];
   wire rx_bit_s = pin_s2[16];
   wire ref_s = pin_s2[17];

   reg tx_parallel_clock_d;
   reg ref_d;
   always @(posedge clk) begin
      if (!rstn) begin
         tx_parallel_clock_d <= 1'b0;
         ref_d <= 1'b0;
      end else begin
         tx_parallel_clock_d <= tx_parallel_clock_s;
         ref_d <= ref_s;
      end
   end
   wire tx_parallel_clock_rise = tx_parallel_clock_s & ~tx_parallel_clock_d;
   wire tx_parallel_clock_fall = ~tx_parallel_clock_s & tx_parallel_clock_d;
   wire ref_rise = ref_s & ~ref_d;

   // control register
   reg rx_oe_reg;
   reg rx_edge_reg;

   // ---------------- serializer ----------------
   wire tx_sleep = ~wake_s; // see (R19)
   reg [9:0] tx_lock_cnt;
   reg tx_locked;
   always @(posedge clk) begin
      if (!rstn || tx_sleep) begin // see (R20)
         tx_lock_cnt <= 10'h000;
         tx_locked <= 1'b0;
      end else if (tx_parallel_clock_rise && !tx_locked) begin
         // lock lands on the 510th edge, plus synchroniser latency
         if (tx_lock_cnt == `ECS_TX_LOCK_CYCLES - 10'h001) begin // see (R24)
            tx_locked <= 1'b1;
         end
         tx_lock_cnt <= tx_lock_cnt + 10'h001;
      end
   end

   wire sync_any = sync_a_s | sync_b_s; // see (R4)
   reg [2:0] sync_cnt;
   always @(posedge clk) begin
      if (!rstn || !sync_any) begin
         sync_cnt <= 3'h0;
      end else if (tx_parallel_clock_rise && sync_cnt != `ECS_SYNC_IGNORE_CYCLES) begin
         sync_cnt <= sync_cnt + 3'h1; // see (R27)
      end
   end
   wire tx_ignore = sync_any && (sync_cnt == `ECS_SYNC_IGNORE_CYCLES); // see (R8)

   reg [9:0] tx_word;
   wire tx_take = tx_edge_select_edge(edge_s, tx_parallel_clock_rise, tx_parallel_clock_fall);
   function tx_edge_select_edge;
      input sel;
      input r;
      input f;
      begin
         tx_edge_select_edge = sel ? r : f; // see (R7)
      end
   endfunction

   always @(posedge clk) begin
      if (!rstn) begin
         tx_word <= 10'h000;
      end else if (tx_take && tx_locked && !tx_ignore) begin
         tx_word <= din_s;
      end
   end

   // frame shifter; only the latest sampled word is framed at each frame start
   reg [3:0] tx_bit_idx;
   reg [10:0] tx_shift;
   wire [11:0] next_frame = sync_any ? `ECS_SYNC_FRAME : // see (R3)
                            {`ECS_STOP_BIT, tx_word, `ECS_START_BIT}; // see (R9)
   always @(posedge clk) begin
      if (!rstn || !tx_locked) begin
         tx_bit_idx <= 4'h0;
         tx_shift <= 11'h000;
         tx_serial_out <= 1'b0;
      end else begin
         if (tx_bit_idx == `ECS_FRAME_LAST) begin // see (R10)
            tx_bit_idx <= 4'h0;
         end else begin
            tx_bit_idx <= tx_bit_idx + 4'h1;
         end
         if (tx_bit_idx == 4'h0) begin
            tx_serial_out <= next_frame[0]; // see (R26)
            tx_shift <= next_frame[11:1];
         end else begin
            tx_serial_out <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[10:1]};
         end
      end
   end

   // enable only gates the driver, so re-enabling resumes the same stream
   always @(posedge clk) begin
      if (!rstn) begin
         tx_serial_oe <= 1'b0; // see (R1)
      end else begin
         tx_serial_oe <= tx_locked & tx_oe_s & wake_s; // see (R11) see (R22)
      end
   end

   // ---------------- deserializer ----------------
   wire rx_sleep = ~wake_s & ~rx_oe_reg; // see (R19)
   reg [4:0] ref_cnt;
   reg rx_pll_ok;
   always @(posedge clk) begin
      if (!rstn || rx_sleep) begin // see (R20)
         ref_cnt <= 5'h00;
         rx_pll_ok <= 1'b0;
      end else if (ref_rise && !rx_pll_ok) begin
         if (ref_cnt == REF_EDGES - 5'h01) begin // see (R2)
            rx_pll_ok <= 1'b1;
         end
         ref_cnt <= ref_cnt + 5'h01;
      end
   end

   // newest bit in [0]; a frame ends when [11] is a start and [0] a stop
   reg [11:0] rx_sh;
   reg [3:0] rx_ph;
   always @(posedge clk) begin
      if (!rstn || rx_sleep) begin
         rx_sh <= 12'h000;
         rx_ph <= 4'h0;
      end else begin
         rx_sh <= {rx_sh[10:0], rx_bit_s};
         if (rx_ph == `ECS_FRAME_LAST) begin
            rx_ph <= 4'h0;
         end else begin
            rx_ph <= rx_ph + 4'h1;
         end
      end
   end
   wire frame_match = rx_sh[11] & ~rx_sh[0];

   wire [9:0] rx_word;
   wire [11:0] cand;
   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1) begin : g_word
         assign rx_word[g] = rx_sh[10 - g]; // see (R26)
      end
      // one confidence counter per bit phase; random data leaves one survivor
      for (g = 0; g < 12; g = g + 1) begin : g_phase
         reg [3:0] hits;
         always @(posedge clk) begin
            if (!rstn || rx_sleep || !rx_pll_ok) begin
               hits <= 4'h0;
            end else if (rx_ph == g) begin
               if (!frame_match) begin
                  hits <= 4'h0;
               end else if (hits != LOCK_FRAMES) begin
                  hits <= hits + 4'h1; // see (R16)
               end
            end
         end
         assign cand[g] = (hits == LOCK_FRAMES);
      end
   endgenerate

   // a held 0-1 data pair repeats a start/stop look-alike at another phase
   wire [3:0] n_cand = ones_count(cand);
   wire ambiguous = (n_cand > 4'h1); // see (R17) see (R18)

   reg [3:0] rx_state;
   reg [3:0] next_rx_state;
   reg [3:0] lock_ph;
   reg [3:0] loss_cnt;
   wire [3:0] mid_ph = (lock_ph >= `ECS_HALF_FRAME) ? lock_ph - `ECS_HALF_FRAME :
                       lock_ph + `ECS_HALF_FRAME;

   always @* begin
      next_rx_state = rx_state;
      case (rx_state)
         ST_SLEEP: begin
            if (!rx_sleep) begin
               next_rx_state = ST_ACQ; // see (R21)
            end
         end
         ST_ACQ: begin
            if (rx_pll_ok) begin
               next_rx_state = ST_HUNT;
            end
         end
         ST_HUNT: begin
            if (n_cand == 4'h1) begin
               next_rx_state = ST_LOCK;
            end
         end
         ST_LOCK: begin
            // a released or idle line breaks the locked phase
            if (!cand[lock_ph] || ambiguous) begin // see (R14) see (R25)
               next_rx_state = ST_HUNT;
            end
         end
         default: begin
            next_rx_state = ST_SLEEP;
         end
      endcase
      if (rx_sleep) begin
         next_rx_state = ST_SLEEP;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         rx_state <= ST_SLEEP;
         lock_ph <= 4'h0;
         loss_cnt <= 4'h0;
      end else begin
         rx_state <= next_rx_state;
         if (rx_state == ST_HUNT && next_rx_state == ST_LOCK) begin
            lock_ph <= first_index(cand);
         end
         if (rx_state == ST_LOCK && next_rx_state != ST_LOCK && loss_cnt != 4'hF) begin
            loss_cnt <= loss_cnt + 4'h1;
         end
      end
   end

   wire rx_locked = (rx_state == ST_LOCK);

   always @(posedge clk) begin
      if (!rstn) begin
         rx_lock_n <= 1'b1;
         rx_parallel_oe <= 1'b0;
         rx_clock_oe <= 1'b0;
      end else begin
         rx_lock_n <= ~rx_locked; // see (R5) see (R6) see (R23)
         rx_parallel_oe <= rx_locked & rx_oe_reg; // see (R12) see (R14) see (R23)
         rx_clock_oe <= rx_locked & rx_oe_reg;
      end
   end

   // data changes on the idle edge; the active edge comes half a frame later
   always @(posedge clk) begin
      if (!rstn) begin
         rx_parallel_out <= 10'h000;
         rx_recovered_clock <= 1'b0;
      end else if (rx_locked) begin
         if (rx_ph == lock_ph && frame_match) begin
            rx_parallel_out <= rx_word; // see (R6)
            rx_recovered_clock <= ~rx_edge_reg; // see (R13)
         end else if (rx_ph == mid_ph) begin
            rx_recovered_clock <= rx_edge_reg;
         end
      end
   end

   // ---------------- wishbone slave ----------------
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   reg [31:0] rd_val;
   always @* begin
      rd_val = 32'h00000000;
      case (wb_adr_i)
         `ECS_CTRL_OFS: begin
            rd_val[`ECS_CTRL_RX_OE] = rx_oe_reg;
            rd_val[`ECS_CTRL_RX_EDGE] = rx_edge_reg;
         end
         `ECS_STAT_OFS: begin
            rd_val[`ECS_STAT_RX_LOCK] = rx_locked;
            rd_val[`ECS_STAT_TX_LOCK] = tx_locked;
            rd_val[`ECS_STAT_AMBIG] = ambiguous;
            rd_val[`ECS_STAT_TX_SYNC] = sync_any;
            rd_val[`ECS_STAT_TX_IGNORE] = tx_ignore;
            rd_val[`ECS_STAT_RX_SLEEP] = rx_sleep;
            rd_val[`ECS_STAT_TX_SLEEP] = tx_sleep;
            rd_val[`ECS_STAT_RX_PLL] = rx_pll_ok;
         end
         `ECS_CAND_OFS: begin
            rd_val[11:0] = cand;
         end
         `ECS_LOSS_OFS: begin
            rd_val[3:0] = loss_cnt;
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         rx_oe_reg <= `ECS_CTRL_RX_OE_RST;
         rx_edge_reg <= `ECS_CTRL_RX_EDGE_RST;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= rd_val;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == `ECS_CTRL_OFS) begin
               rx_oe_reg <= wb_dat_i[`ECS_CTRL_RX_OE];
               rx_edge_reg <= wb_dat_i[`ECS_CTRL_RX_EDGE];
            end
         end
      end
   end

endmodule // ecs_serdes
`default_nettype wire

// file: verification/ecs_serdes_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ecs_serdes_sva (
   // system
   input wire logic clk,
   input wire logic rstn,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // serializer
   input wire logic tx_parallel_clock,
   input wire logic tx_output_enable,
   input wire logic sleep_control_n,
   input wire logic tx_serial_out,
   input wire logic tx_serial_oe,
   // deserializer
   input wire logic [9:0] rx_parallel_out,
   input wire logic rx_parallel_oe,
   input wire logic rx_recovered_clock,
   input wire logic rx_clock_oe,
   input wire logic rx_lock_n
);
   logic [2:0] tck;
   logic [1:0] wk;
   logic [9:0] tcnt;
   logic [3:0] run;
   logic last;
   // clock and wake pass the same two flops as in the design, so the count
   // clears when the design's lock clears; slack below 510 covers reset edges
   always @(posedge clk) begin
      tck <= {tck[1:0], tx_parallel_clock};
      wk <= {wk[0], sleep_control_n};
      last <= tx_serial_out;
      if (!rstn || !wk[1]) begin
         tcnt <= 10'h000;
      end else if (tck[1] && !tck[2] && tcnt != 10'h258) begin
         tcnt <= tcnt + 10'h001;
      end
      if (!rstn || !tx_serial_oe || tx_serial_out != last) begin
         run <= 4'h0;
      end else if (run != 4'hF) begin
         run <= run + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_init_quiet: assert property (tcnt < 10'h1FC |-> !tx_serial_oe)
      else $error("serial driven before lock");
   a_lock_window: assert property (tcnt == 10'h203 && tx_output_enable && sleep_control_n
      |-> ##[0:12] tx_serial_oe) else $error("serial not driven after lock window");
   a_enable_gate: assert property ((!tx_output_enable) [*4] |-> !tx_serial_oe)
      else $error("serial driven while disabled");
   a_sleep_gate: assert property ((!sleep_control_n) [*4] |-> !tx_serial_oe)
      else $error("serial driven while asleep");
   a_run_bound: assert property (run < 4'hB)
      else $error("no framing transition within a frame");
   a_loss_release: assert property ($rose(rx_lock_n) |=> !rx_parallel_oe && !rx_clock_oe)
      else $error("outputs kept after loss of lock");
   a_valid_lock: assert property (rx_lock_n [*2] |-> !rx_parallel_oe)
      else $error("parallel output driven without lock");
   a_release_loss: assert property ($fell(tx_serial_oe) |-> ##[1:200] rx_lock_n)
      else $error("lock kept after serial release");
   a_rclk_edge: assert property ($changed(rx_parallel_out) && rx_parallel_oe && $past(rx_parallel_oe)
      |-> $changed(rx_recovered_clock)) else $error("word update off recovered clock");
   a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a single pulse one cycle on");
   c_locked: cover property (!rx_lock_n && rx_parallel_oe);
   c_release: cover property ($fell(tx_serial_oe));
   c_drive: cover property ($rose(tx_serial_oe));
endmodule // ecs_serdes_sva
bind ecs_serdes ecs_serdes_sva u_sva (
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .tx_parallel_clock(tx_parallel_clock), .tx_output_enable(tx_output_enable),
   .sleep_control_n(sleep_control_n), .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe),
   .rx_parallel_out(rx_parallel_out), .rx_parallel_oe(rx_parallel_oe),
   .rx_recovered_clock(rx_recovered_clock), .rx_clock_oe(rx_clock_oe), .rx_lock_n(rx_lock_n)
);
`default_nettype wire

// file: verification/ecs_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ecs_far_end (
   // system
   input wire logic clk,
   input wire logic loop_en,
   // from the block
   input wire logic tx_serial_out,
   input wire logic tx_serial_oe,
   input wire logic rx_lock_n,
   // to the block
   output var logic tx_parallel_clock,
   output var logic rx_reference_clock,
   output var logic rx_serial_in,
   output logic sync_request_a
);
   initial begin
      tx_parallel_clock = 1'b0;
      rx_reference_clock = 1'b0;
      rx_serial_in = 1'b0;
   end
   // source word clock runs free, unrelated to clk
   always #62.5 tx_parallel_clock = ~tx_parallel_clock;
   always #45 rx_reference_clock = ~rx_reference_clock;
   // a released line must not hold its last level, so it toggles
   always @(posedge clk) begin
      if (tx_serial_oe) begin
         rx_serial_in <= tx_serial_out;
      end else begin
         rx_serial_in <= ~rx_serial_in;
      end
   end
   assign sync_request_a = loop_en & rx_lock_n;
endmodule // ecs_far_end
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecs_regs.vh"
module tb_top;
   logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, loop_en;
   logic [3:0] wb_sel_i;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, q;
   logic sync_request_b, tx_edge_select, tx_output_enable, sleep_control_n;
   logic [9:0] tx_parallel_in;
   logic [11:0] f;
   wire wb_ack_o, tx_parallel_clock, sync_request_a, tx_serial_out, tx_serial_oe, rx_serial_in;
   wire rx_reference_clock, rx_parallel_oe, rx_recovered_clock, rx_clock_oe, rx_lock_n;
   wire [31:0] wb_dat_o;
   wire [9:0] rx_parallel_out;
   integer n_mismatch, n_compared;
   ecs_serdes #(.REF_EDGES(5'h02)) uut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .tx_parallel_clock(tx_parallel_clock), .sync_request_a(sync_request_a),
      .sync_request_b(sync_request_b), .tx_edge_select(tx_edge_select),
      .tx_output_enable(tx_output_enable), .sleep_control_n(sleep_control_n),
      .tx_parallel_in(tx_parallel_in), .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe),
      .rx_serial_in(rx_serial_in), .rx_reference_clock(rx_reference_clock),
      .rx_parallel_out(rx_parallel_out), .rx_parallel_oe(rx_parallel_oe),
      .rx_recovered_clock(rx_recovered_clock), .rx_clock_oe(rx_clock_oe), .rx_lock_n(rx_lock_n));
   ecs_far_end far (.clk(clk), .loop_en(loop_en), .tx_serial_out(tx_serial_out),
      .tx_serial_oe(tx_serial_oe), .rx_lock_n(rx_lock_n), .tx_parallel_clock(tx_parallel_clock),
      .rx_reference_clock(rx_reference_clock), .rx_serial_in(rx_serial_in),
      .sync_request_a(sync_request_a));
   always #5 clk = ~clk;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // one classic cycle; read data lands in q
   task xfer(input [7:0] a, input w, input [3:0] s, input [31:0] d);
      integer i;
      begin
         @(posedge clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_sel_i <= s;
         wb_adr_i <= a;
         wb_dat_i <= d;
         i = 0;
         @(posedge clk);
         // no limit here; if ack never comes only the watchdog ends this wait
         while (wb_ack_o !== 1'b1) begin
            @(posedge clk);
            i = i + 1;
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
         // ack is seen one edge after the taking edge
         chk(i, 1);
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task wait_lock(input logic exp, input integer lim);
      integer i, n;
      begin
         n = 0;
         // a lone stale phase can hold lock for a cycle or two; wait until it settles
         for (i = 0; n < 24 && i < lim; i = i + 1) begin
            @(posedge clk);
            n = (rx_lock_n === exp) ? n + 1 : 0;
         end
         chk(rx_lock_n, exp);
      end
   endtask
   task wait_oe(input integer lim);
      integer i;
      begin
         for (i = 0; tx_serial_oe !== 1'b1 && i < lim; i = i + 1) @(posedge clk);
         chk(tx_serial_oe, 1);
      end
   endtask
   // the frame boundary is the only low-high step in the frames grabbed here
   task grab;
      integer i;
      logic prev;
      begin
         prev = 1'b1;
         i = 0;
         @(posedge clk);
         while (!(prev === 1'b0 && tx_serial_out === 1'b1) && i < 100) begin
            prev = tx_serial_out;
            @(posedge clk);
            i = i + 1;
         end
         for (i = 0; i < 12; i = i + 1) begin
            if (i > 0) @(posedge clk);
            f[i] = tx_serial_out;
         end
      end
   endtask
   task t_reset;
      begin
         idle(1);
         chk(rx_lock_n, 1);
         chk(tx_serial_oe, 0);
         xfer(`ECS_CTRL_OFS, 1'b1, 4'hE, 32'h0);
         xfer(`ECS_CTRL_OFS, 1'b0, 4'hF, 32'h0);
         chk(q, {30'h0, `ECS_CTRL_RX_EDGE_RST, `ECS_CTRL_RX_OE_RST});
         xfer(8'h10, 1'b0, 4'hF, 32'h0);
         chk(q, 32'h0);
      end
   endtask
   task t_sync;
      begin
         sync_request_b <= 1'b1;
         tx_parallel_in <= 10'h3FF;
         wait_oe(7000);
         grab;
         chk(f, `ECS_SYNC_FRAME);
         wait_lock(1'b0, 1500);
         xfer(`ECS_STAT_OFS, 1'b0, 4'hF, 32'h0);
         chk(q[4:0], 5'h1B);
      end
   endtask
   task t_data;
      begin
         sync_request_b <= 1'b0;
         idle(100);
         grab;
         chk(f, {`ECS_STOP_BIT, 10'h3FF, `ECS_START_BIT});
         chk(rx_parallel_out, 10'h3FF);
         chk(rx_parallel_oe, 1);
         tx_edge_select <= 1'b0;
         tx_parallel_in <= 10'h000;
         idle(150);
         grab;
         chk(f, {`ECS_STOP_BIT, 10'h000, `ECS_START_BIT});
         chk(rx_parallel_out, 10'h000);
         tx_edge_select <= 1'b1;
      end
   endtask
   task t_rmt;
      begin
         tx_parallel_in <= 10'h002;
         idle(200);
         chk(rx_lock_n, 1);
         xfer(`ECS_STAT_OFS, 1'b0, 4'hF, 32'h0);
         chk(q[`ECS_STAT_AMBIG], 1);
         tx_parallel_in <= 10'h1FF;
         wait_lock(1'b0, 1500);
         idle(30);
         chk(rx_parallel_out, 10'h1FF);
      end
   endtask
   task t_den;
      begin
         loop_en <= 1'b1;
         tx_output_enable <= 1'b0;
         idle(8);
         chk(tx_serial_oe, 0);
         wait_lock(1'b1, 300);
         idle(2);
         chk({rx_parallel_oe, rx_clock_oe}, 0);
         tx_output_enable <= 1'b1;
         idle(8);
         chk(tx_serial_oe, 1);
         wait_lock(1'b0, 1500);
         idle(100);
         xfer(`ECS_STAT_OFS, 1'b0, 4'hF, 32'h0);
         chk(q[`ECS_STAT_TX_SYNC], 0);
      end
   endtask
   task t_rxoe;
      begin
         xfer(`ECS_CTRL_OFS, 1'b1, 4'hF, 32'h2);
         idle(4);
         chk({rx_parallel_oe, rx_clock_oe, rx_lock_n}, 0);
      end
   endtask
   task t_sleep;
      begin
         sleep_control_n <= 1'b0;
         idle(20);
         chk({tx_serial_oe, rx_lock_n}, 1);
         xfer(`ECS_STAT_OFS, 1'b0, 4'hF, 32'h0);
         chk(q[7:5], 3'b011);
         sleep_control_n <= 1'b1;
         xfer(`ECS_CTRL_OFS, 1'b1, 4'hF, 32'h3);
         idle(400);
         chk({tx_serial_oe, rx_lock_n}, 1);
         wait_oe(7000);
         wait_lock(1'b0, 2000);
         idle(30);
         chk(rx_parallel_out, 10'h1FF);
      end
   endtask
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, loop_en, sync_request_b} = 5'h00;
      {wb_sel_i, wb_adr_i, wb_dat_i} = 44'h0;
      {tx_edge_select, tx_output_enable, sleep_control_n} = 3'h7;
      tx_parallel_in = 10'h000;
      n_mismatch = 0;
      n_compared = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_sync;
      t_data;
      t_rmt;
      t_den;
      t_rxoe;
      t_sleep;
      close_out;
   end
   // the whole run needs about 140 us
   initial begin
      #400000;
      n_mismatch = n_mismatch + 1;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
